// >>> rtl/ssp_pin_sync.sv
// Pin synchroniser and serial clock edge finder
`timescale 1ns/10ps
module ssp_pin_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire ssp_pkg::ssp_pins_type pins_async,
    output ssp_pkg::ssp_pins_type pins_sync,
    output logic sck_rise,
    output logic sck_fall
);
    import ssp_pkg::*;

    ssp_pins_type meta_ff;
    ssp_pins_type sync_ff;
    logic sck_prev_ff;

    // Reset pin idles high so the port starts outside programming
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff <= '{rst_n: 1'b1, sck: 1'b0, mosi: 1'b0};
            sync_ff <= '{rst_n: 1'b1, sck: 1'b0, mosi: 1'b0};
            sck_prev_ff <= 1'b0;
        end else begin
            meta_ff <= pins_async;
            sync_ff <= meta_ff;
            sck_prev_ff <= sync_ff.sck;
        end
    end

    assign pins_sync = sync_ff;
    assign sck_rise = sync_ff.sck & ~sck_prev_ff;
    assign sck_fall = ~sync_ff.sck & sck_prev_ff;
endmodule

// >>> rtl/ssp_pkg.sv
// Constants and types shared by the serial programming port
package ssp_pkg;
    // Clock and wait times
    localparam int CLK_FREQ_MHZ = 100;
    localparam real FLASH_WAIT_MS = 4.5;
    localparam real EEPROM_WAIT_MS = 9.0;
    localparam int FLASH_WAIT_CYC = int'(FLASH_WAIT_MS * 1000.0 * CLK_FREQ_MHZ);
    localparam int EEPROM_WAIT_CYC = int'(EEPROM_WAIT_MS * 1000.0 * CLK_FREQ_MHZ);
    localparam int CNT_W = 20;

    // Instruction bytes
    localparam logic [7:0] OPC_AC_GROUP = 8'hAC;
    localparam logic [7:0] SUB_PROG_EN = 8'h53;
    localparam logic [7:0] SUB_ERASE = 8'h80;
    localparam logic [7:0] SUB_WR_LOCK = 8'hE0;
    localparam logic [7:0] SUB_WR_FUSE_LO = 8'hA0;
    localparam logic [7:0] SUB_WR_FUSE_HI = 8'hA8;
    localparam logic [7:0] SUB_WR_FUSE_EXT = 8'hA4;
    localparam logic [7:0] OPC_POLL = 8'hF0;
    localparam logic [7:0] OPC_LOAD_EXT = 8'h4D;
    localparam logic [7:0] OPC_LOAD_LO = 8'h40;
    localparam logic [7:0] OPC_LOAD_HI = 8'h48;
    localparam logic [7:0] OPC_LOAD_EE = 8'hC1;
    localparam logic [7:0] OPC_RD_LO = 8'h20;
    localparam logic [7:0] OPC_RD_HI = 8'h28;
    localparam logic [7:0] OPC_RD_EE = 8'hA0;
    localparam logic [7:0] OPC_RD_LOCK_FH = 8'h58;
    localparam logic [7:0] OPC_RD_FL_EXT = 8'h50;
    localparam logic [7:0] OPC_RD_SIG = 8'h30;
    localparam logic [7:0] OPC_RD_CAL = 8'h38;
    localparam logic [7:0] OPC_WR_PAGE = 8'h4C;
    localparam logic [7:0] OPC_WR_EE = 8'hC0;
    localparam logic [7:0] OPC_WR_EE_PAGE = 8'hC2;
    localparam int HI_SEL_BIT = 3;

    // Memory geometry
    localparam int FLASH_WORDS = 16384;
    localparam int FLASH_AW = 14;
    localparam int PAGE_WORDS = 64;
    localparam int PAGE_AW = 6;
    localparam int EE_BYTES = 1024;
    localparam int EE_AW = 10;
    localparam int EE_PAGE_BYTES = 4;
    localparam int EE_PAGE_AW = 2;

    // Reset and erased values
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;
    localparam logic [7:0] FUSE_RST = 8'hFF;
    localparam logic [7:0] CAL_RST = 8'h80;

    // Register map
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_CAL = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;
    localparam logic [11:0] ADDR_CFG = 12'h00C;
    localparam int CTRL_EN_BIT = 0;
    localparam logic CTRL_EN_RST = 1'b1;

    typedef struct packed {
        logic rst_n;
        logic sck;
        logic mosi;
    } ssp_pins_type;

    typedef enum logic [2:0] {
        OP_IDLE,
        OP_ERASE,
        OP_FLASH,
        OP_FUSE,
        OP_EE_BYTE,
        OP_EE_PAGE
    } ssp_op_type;
endpackage

// >>> rtl/ssp_prog_port.sv
// Serial in-system programming port with APB status and control
//
// Behaviour
// - Ignore operations until programming enable received
// - Sample on rising, drive on falling
// - Echo second enable byte during third
// - Chip erase fills both arrays 0xFF
// - Poll returns pending flag in LSB
// - Page load writes low/high buffer bytes
// - Page write commits buffer to page
// - EEPROM byte write is self-timed
// - EEPROM page write alters loaded bytes
// - Reads return memory in fourth byte
// - Configuration bytes returned in fourth byte
// - Fuse and lock writes store byte
// - Accept extended address byte
// - Word addresses, any order in page
// - Reset high leaves programming mode
`timescale 1ns/10ps
module ssp_prog_port #(
    parameter int FLASH_WAIT = ssp_pkg::FLASH_WAIT_CYC,
    parameter int EEPROM_WAIT = ssp_pkg::EEPROM_WAIT_CYC,
    // Signature bytes: arbitrary neutral values
    parameter logic [7:0] SIG_BYTE0 = 8'h11,
    parameter logic [7:0] SIG_BYTE1 = 8'h22,
    parameter logic [7:0] SIG_BYTE2 = 8'h33
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire ssp_pkg::ssp_pins_type pins_async,
    output logic miso,
    output logic miso_oe,
    output logic cpu_run
);
    import ssp_pkg::*;

    ssp_pins_type pins_s;
    logic sck_rise;
    logic sck_fall;

    ssp_pin_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pins_async(pins_async),
        .pins_sync(pins_s),
        .sck_rise(sck_rise),
        .sck_fall(sck_fall)
    );

    // Registers
    logic ctrl_en_ff;
    logic [7:0] cal_ff;
    logic pe_ok_ff;
    logic [7:0] rx_ff;
    logic [2:0] bit_cnt_ff;
    logic [1:0] byte_idx_ff;
    logic [23:0] instr_ff;
    logic [7:0] tx_ff;
    logic miso_ff;
    logic miso_oe_ff;
    logic cpu_run_ff;
    logic [7:0] lock_ff;
    logic [7:0] fuse_lo_ff;
    logic [7:0] fuse_hi_ff;
    logic [7:0] fuse_ext_ff;
    logic [7:0] ext_addr_ff;
    logic [7:0] last_opc_ff;
    logic [7:0] page_ff;
    logic [EE_AW-1:0] ee_addr_ff;
    logic [7:0] ee_data_ff;
    logic [EE_PAGE_BYTES-1:0] ee_mask_ff;
    ssp_op_type op_ff;
    ssp_op_type nxt_op;
    logic [CNT_W-1:0] cnt_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;

    logic [15:0] flash_mem [FLASH_WORDS];
    logic [7:0] ee_mem [EE_BYTES];
    logic [15:0] page_buf [PAGE_WORDS];
    logic [7:0] ee_buf [EE_PAGE_BYTES];

    // Serial framing
    wire prog_mode = ~pins_s.rst_n & ctrl_en_ff;
    wire busy = (op_ff != OP_IDLE);
    wire [7:0] new_byte = {rx_ff[6:0], pins_s.mosi};
    wire byte_done = prog_mode & sck_rise & (bit_cnt_ff == 3'd7);
    wire instr_done = byte_done & (byte_idx_ff == 2'd3);

    // Bytes of a complete instruction
    wire [7:0] x_b1 = instr_ff[23:16];
    wire [7:0] x_b2 = instr_ff[15:8];
    wire [7:0] x_b3 = instr_ff[7:0];
    wire [7:0] x_b4 = new_byte;
    // Bytes seen when the reply is prepared
    wire [7:0] r_b1 = instr_ff[15:8];
    wire [7:0] r_b2 = instr_ff[7:0];
    wire [7:0] r_b3 = new_byte;

    wire [FLASH_AW-1:0] rd_word_addr = {r_b2[5:0], r_b3};
    wire [EE_AW-1:0] rd_ee_addr = {r_b2[1:0], r_b3};
    wire [15:0] rd_word = flash_mem[rd_word_addr];

    // Fourth byte answer
    function automatic logic [7:0] reply_byte(input logic [7:0] b1, input logic [7:0] b2,
                                              input logic [7:0] b3, input logic [15:0] word,
                                              input logic [7:0] ee_byte, input logic pend);
        logic [7:0] r;
        r = 8'h00;
        unique case (b1)
            OPC_POLL: r = {7'h00, pend};
            OPC_RD_LO: r = word[7:0];
            OPC_RD_HI: r = word[15:8];
            OPC_RD_EE: r = ee_byte;
            OPC_RD_LOCK_FH: r = b2[HI_SEL_BIT] ? fuse_hi_ff : lock_ff;
            OPC_RD_FL_EXT: r = b2[HI_SEL_BIT] ? fuse_ext_ff : fuse_lo_ff;
            OPC_RD_SIG: r = (b3[1:0] == 2'd0) ? SIG_BYTE0 :
                            (b3[1:0] == 2'd1) ? SIG_BYTE1 : SIG_BYTE2;
            OPC_RD_CAL: r = cal_ff;
            default: r = 8'h00;
        endcase
        return r;
    endfunction

    wire [7:0] reply = pe_ok_ff ? reply_byte(r_b1, r_b2, r_b3, rd_word, ee_mem[rd_ee_addr], busy)
                                : 8'h00;
    wire [7:0] nxt_tx = (byte_idx_ff == 2'd1) ? new_byte :
                        (byte_idx_ff == 2'd2) ? reply : 8'h00;

    // Instruction decode
    wire is_ac = (x_b1 == OPC_AC_GROUP);
    wire go_pe = instr_done & is_ac & (x_b2 == SUB_PROG_EN);
    wire exec_ok = instr_done & pe_ok_ff & ~busy;
    wire go_erase = exec_ok & is_ac & (x_b2 == SUB_ERASE);
    wire go_lock = exec_ok & is_ac & (x_b2 == SUB_WR_LOCK);
    wire go_fl = exec_ok & is_ac & (x_b2 == SUB_WR_FUSE_LO);
    wire go_fh = exec_ok & is_ac & (x_b2 == SUB_WR_FUSE_HI);
    wire go_fx = exec_ok & is_ac & (x_b2 == SUB_WR_FUSE_EXT);
    wire go_fuse = go_lock | go_fl | go_fh | go_fx;
    wire go_ld_lo = exec_ok & (x_b1 == OPC_LOAD_LO);
    wire go_ld_hi = exec_ok & (x_b1 == OPC_LOAD_HI);
    wire go_ext = exec_ok & (x_b1 == OPC_LOAD_EXT);
    wire go_wr_page = exec_ok & (x_b1 == OPC_WR_PAGE);
    wire go_ee_byte = exec_ok & (x_b1 == OPC_WR_EE);
    wire go_ld_ee = exec_ok & (x_b1 == OPC_LOAD_EE);
    wire go_ee_page = exec_ok & (x_b1 == OPC_WR_EE_PAGE);

    // Self-timed operation length
    wire long_op = (op_ff == OP_ERASE) | (op_ff == OP_EE_BYTE) | (op_ff == OP_EE_PAGE);
    wire [CNT_W-1:0] wait_last = long_op ? CNT_W'(EEPROM_WAIT - 1) : CNT_W'(FLASH_WAIT - 1);
    wire op_end = busy & (cnt_ff == wait_last);

    always_comb begin
        nxt_op = op_ff;
        if (op_ff == OP_IDLE) begin
            if (go_erase) begin
                nxt_op = OP_ERASE;
            end else if (go_wr_page) begin
                nxt_op = OP_FLASH;
            end else if (go_fuse) begin
                nxt_op = OP_FUSE;
            end else if (go_ee_byte) begin
                nxt_op = OP_EE_BYTE;
            end else if (go_ee_page) begin
                nxt_op = OP_EE_PAGE;
            end
        end else if (op_end) begin
            nxt_op = OP_IDLE;
        end
    end

    // Memory write ports, one location per cycle
    wire erase_flash = (op_ff == OP_ERASE) & (cnt_ff < CNT_W'(FLASH_WORDS));
    wire erase_ee = (op_ff == OP_ERASE) & (cnt_ff < CNT_W'(EE_BYTES));
    wire [PAGE_AW-1:0] cnt_word = cnt_ff[PAGE_AW-1:0];
    wire [EE_PAGE_AW-1:0] cnt_eb = cnt_ff[EE_PAGE_AW-1:0];
    wire flash_we = erase_flash | ((op_ff == OP_FLASH) & (cnt_ff < CNT_W'(PAGE_WORDS)));
    wire [FLASH_AW-1:0] flash_wa = erase_flash ? cnt_ff[FLASH_AW-1:0] : {page_ff, cnt_word};
    wire [15:0] flash_wd = erase_flash ? ERASED_WORD : page_buf[cnt_word];
    wire ee_pg_we = (op_ff == OP_EE_PAGE) & (cnt_ff < CNT_W'(EE_PAGE_BYTES)) & ee_mask_ff[cnt_eb];
    wire ee_by_we = (op_ff == OP_EE_BYTE) & (cnt_ff == '0);
    wire ee_we = erase_ee | ee_by_we | ee_pg_we;
    wire [EE_AW-1:0] ee_wa = erase_ee ? cnt_ff[EE_AW-1:0] :
                             ee_by_we ? ee_addr_ff : {ee_addr_ff[EE_AW-1:EE_PAGE_AW], cnt_eb};
    wire [7:0] ee_wd = erase_ee ? ERASED_BYTE : ee_by_we ? ee_data_ff : ee_buf[cnt_eb];

    always_ff @(posedge pclk) begin
        if (flash_we) begin
            flash_mem[flash_wa] <= flash_wd;
        end
        if (ee_we) begin
            ee_mem[ee_wa] <= ee_wd;
        end
    end

    always_ff @(posedge pclk) begin
        if (go_ld_lo) begin
            page_buf[x_b3[PAGE_AW-1:0]][7:0] <= x_b4;
        end
        if (go_ld_hi) begin
            page_buf[x_b3[PAGE_AW-1:0]][15:8] <= x_b4;
        end
        if (go_ld_ee) begin
            ee_buf[x_b3[EE_PAGE_AW-1:0]] <= x_b4;
        end
    end

    // Operation sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_ff <= OP_IDLE;
            cnt_ff <= '0;
        end else begin
            op_ff <= nxt_op;
            cnt_ff <= (busy && !op_end) ? cnt_ff + 1'b1 : '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            page_ff <= 8'h00;
            ee_addr_ff <= '0;
            ee_data_ff <= 8'h00;
            ext_addr_ff <= 8'h00;
            ee_mask_ff <= '0;
        end else begin
            if (go_wr_page) begin
                page_ff <= {x_b2[5:0], x_b3[7:6]};
            end
            if (go_ee_byte || go_ee_page) begin
                ee_addr_ff <= {x_b2[1:0], x_b3};
                ee_data_ff <= x_b4;
            end
            if (go_ext) begin
                ext_addr_ff <= x_b3;
            end
            if (go_ld_ee) begin
                ee_mask_ff[x_b3[EE_PAGE_AW-1:0]] <= 1'b1;
            end else if (op_end && op_ff == OP_EE_PAGE) begin
                ee_mask_ff <= '0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_ff <= FUSE_RST;
            fuse_lo_ff <= FUSE_RST;
            fuse_hi_ff <= FUSE_RST;
            fuse_ext_ff <= FUSE_RST;
        end else begin
            lock_ff <= go_lock ? x_b4 : go_erase ? ERASED_BYTE : lock_ff;
            fuse_lo_ff <= go_fl ? x_b4 : fuse_lo_ff;
            fuse_hi_ff <= go_fh ? x_b4 : fuse_hi_ff;
            fuse_ext_ff <= go_fx ? x_b4 : fuse_ext_ff;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_ff <= 8'h00;
            bit_cnt_ff <= 3'd0;
            byte_idx_ff <= 2'd0;
            instr_ff <= 24'h0;
            tx_ff <= 8'h00;
            miso_ff <= 1'b0;
            pe_ok_ff <= 1'b0;
            last_opc_ff <= 8'h00;
        end else if (!prog_mode) begin
            bit_cnt_ff <= 3'd0;
            byte_idx_ff <= 2'd0;
            tx_ff <= 8'h00;
            miso_ff <= 1'b0;
            pe_ok_ff <= 1'b0;
        end else if (sck_rise) begin
            rx_ff <= new_byte;
            bit_cnt_ff <= bit_cnt_ff + 3'd1;
            if (byte_done) begin
                byte_idx_ff <= byte_idx_ff + 2'd1;
                instr_ff <= {instr_ff[15:0], new_byte};
                tx_ff <= nxt_tx;
            end
            if (go_pe) begin
                pe_ok_ff <= 1'b1;
            end
            if (instr_done) begin
                last_opc_ff <= x_b1;
            end
        end else if (sck_fall) begin
            miso_ff <= tx_ff[7];
            tx_ff <= {tx_ff[6:0], 1'b0};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            miso_oe_ff <= 1'b0;
            cpu_run_ff <= 1'b0;
        end else begin
            miso_oe_ff <= prog_mode;
            cpu_run_ff <= pins_s.rst_n;
        end
    end

    // APB slave, one-cycle access phase
    wire apb_setup = psel & ~penable;
    wire apb_wr = psel & penable & pready_ff & pwrite & ~pslverr_ff;
    wire hit_ctrl = (paddr == ADDR_CTRL);
    wire hit_cal = (paddr == ADDR_CAL);
    wire hit_stat = (paddr == ADDR_STATUS);
    wire hit_cfg = (paddr == ADDR_CFG);
    wire hit_any = hit_ctrl | hit_cal | hit_stat | hit_cfg;
    wire [31:0] stat_word = {16'h0, last_opc_ff, 5'h0, busy, pe_ok_ff, prog_mode};
    wire [31:0] rd_mux = hit_ctrl ? {31'h0, ctrl_en_ff} :
                         hit_cal ? {24'h0, cal_ff} :
                         hit_stat ? stat_word :
                         hit_cfg ? {fuse_ext_ff, fuse_hi_ff, fuse_lo_ff, lock_ff} : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0;
            ctrl_en_ff <= CTRL_EN_RST;
            cal_ff <= CAL_RST;
        end else begin
            pready_ff <= apb_setup;
            pslverr_ff <= apb_setup & ~hit_any;
            prdata_ff <= (apb_setup && !pwrite) ? rd_mux : 32'h0;
            if (apb_wr && hit_ctrl) begin
                ctrl_en_ff <= pwdata[CTRL_EN_BIT];
            end
            if (apb_wr && hit_cal) begin
                cal_ff <= pwdata[7:0];
            end
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign miso = miso_ff;
    assign miso_oe = miso_oe_ff;
    assign cpu_run = cpu_run_ff;

    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_PE_NEEDS_KEY: assert property ($rose(pe_ok_ff) |-> $past(go_pe))
        else $error("enable set without enable instruction");
    AST_NO_OP_BEFORE_PE: assert property (!pe_ok_ff |=> op_ff == OP_IDLE || $past(busy))
        else $error("operation started before enable");
    AST_MISO_ON_FALL: assert property ($changed(miso_ff) && prog_mode |-> $past(sck_fall))
        else $error("serial output changed off a falling edge");
    AST_ECHO_BYTE: assert property (byte_done && byte_idx_ff == 2'd1 |=> tx_ff == $past(new_byte))
        else $error("second byte not loaded for echo");
    AST_ERASE_RUNS: assert property (go_erase |=> op_ff == OP_ERASE ##1 flash_we && ee_we)
        else $error("chip erase did not start clearing");
    AST_POLL_FLAG: assert property (byte_done && byte_idx_ff == 2'd2 && r_b1 == OPC_POLL
        && pe_ok_ff |=> tx_ff[0] == $past(busy))
        else $error("poll answer does not show pending flag");
    AST_LOAD_LOW: assert property (go_ld_lo |=>
        page_buf[$past(x_b3[PAGE_AW-1:0])][7:0] == $past(x_b4))
        else $error("page buffer low byte not loaded");
    AST_EE_BYTE_WRITE: assert property (go_ee_byte |=> busy ##1 ee_mem[ee_addr_ff] == ee_data_ff)
        else $error("EEPROM byte not written");
    AST_LEAVE_PROG: assert property (!prog_mode |=> !pe_ok_ff && byte_idx_ff == 2'd0)
        else $error("programming state kept after reset release");
    AST_BIT_COUNT: assert property (prog_mode && sck_rise |=>
        bit_cnt_ff == $past(bit_cnt_ff) + 3'd1)
        else $error("bit counter did not advance");
endmodule

// >>> tb/spi_serial_programming_port_bench.sv
// Self-checking bench for the serial programming port
`timescale 1ns/10ps
module spi_serial_programming_port_bench;
    import ssp_pkg::*;
    logic pclk;
    logic presetn;
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    ssp_pins_type pins;
    logic miso;
    logic miso_oe;
    logic cpu_run;
    logic [31:0] rsp;
    int err_total;
    int tests_run;

    ssp_prog_port #(.FLASH_WAIT(1000), .EEPROM_WAIT(17000)) dut_u (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pins_async(pins), .miso(miso), .miso_oe(miso_oe),
        .cpu_run(cpu_run)
    );
    ssp_programmer #(.POWERUP_NS(2000)) prog_u (.pins(pins), .miso(miso));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic give_verdict();
        $display("compares %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic timeout_hit();
        err_total++;
        $display("BAD t=%0t wait ran out", $time);
        give_verdict();
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t byte %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       input logic [31:0] exp, input logic eerr);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) timeout_hit();
        if (!wr) chk_word(prdata, exp);
        chk_word({31'h0, pslverr}, {31'h0, eerr});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rq(input logic [31:0] cmd, input logic [7:0] exp);
        prog_u.xfer(cmd, rsp);
        chk_byte(rsp[7:0], exp);
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        prog_u.xfer({OPC_POLL, 24'h000000}, rsp);
        chk_byte({7'h00, rsp[0]}, 8'h01);
        while (rsp[0] !== 1'b0 && n < 200) begin
            prog_u.xfer({OPC_POLL, 24'h000000}, rsp);
            n++;
        end
        if (rsp[0] !== 1'b0) timeout_hit();
    endtask

    task automatic t_regs();
        apb(1'b0, ADDR_CTRL, '0, 32'h00000001, 1'b0);
        apb(1'b0, ADDR_CAL, '0, 32'h00000080, 1'b0);
        apb(1'b0, ADDR_CFG, '0, 32'hFFFFFFFF, 1'b0);
        apb(1'b0, 12'h010, '0, 32'h00000000, 1'b1);
        apb(1'b1, ADDR_CAL, 32'h0000005A, '0, 1'b0);
        apb(1'b1, ADDR_CFG, 32'h00000000, '0, 1'b0);
        apb(1'b0, ADDR_CAL, '0, 32'h0000005A, 1'b0);
        apb(1'b0, ADDR_CFG, '0, 32'hFFFFFFFF, 1'b0);
        $display("test regs done");
    endtask
    task automatic t_enable();
        logic [7:0] echo;
        rq({OPC_RD_SIG, 24'h000000}, 8'h00);
        prog_u.enable(echo);
        chk_byte(echo, SUB_PROG_EN);
        chk_byte({6'h00, miso_oe, cpu_run}, 8'h02);
        $display("test enable done");
    endtask
    task automatic t_erase();
        prog_u.xfer({OPC_AC_GROUP, SUB_ERASE, 16'h0000}, rsp);
        wait_ready();
        rq({OPC_RD_LO, 8'h01, 8'h55, 8'h00}, ERASED_BYTE);
        rq({OPC_RD_HI, 8'h01, 8'h55, 8'h00}, ERASED_BYTE);
        rq({OPC_RD_EE, 8'h02, 8'hAB, 8'h00}, ERASED_BYTE);
        $display("test erase done");
    endtask
    task automatic t_flash();
        logic [7:0] ix [2] = '{8'h09, 8'h02};
        prog_u.xfer({OPC_LOAD_EXT, 8'h00, 8'h00, 8'h00}, rsp);
        foreach (ix[k]) begin
            prog_u.xfer({OPC_LOAD_LO, 8'h00, ix[k], ix[k] + 8'h10}, rsp);
            prog_u.xfer({OPC_LOAD_HI, 8'h00, ix[k], ix[k] + 8'h70}, rsp);
        end
        prog_u.xfer({OPC_WR_PAGE, 8'h00, 8'hC0, 8'h00}, rsp);
        wait_ready();
        foreach (ix[k]) begin
            rq({OPC_RD_LO, 8'h00, 8'hC0 | ix[k], 8'h00}, ix[k] + 8'h10);
            rq({OPC_RD_HI, 8'h00, 8'hC0 | ix[k], 8'h00}, ix[k] + 8'h70);
        end
        rq({OPC_RD_LO, 8'h01, 8'h09, 8'h00}, ERASED_BYTE);
        $display("test flash done");
    endtask
    task automatic t_eeprom();
        prog_u.xfer({OPC_WR_EE, 8'h01, 8'h23, 8'h3C}, rsp);
        wait_ready();
        prog_u.xfer({OPC_WR_EE, 8'h01, 8'h23, 8'hC3}, rsp);
        wait_ready();
        rq({OPC_RD_EE, 8'h01, 8'h23, 8'h00}, 8'hC3);
        prog_u.xfer({OPC_LOAD_EE, 8'h00, 8'h01, 8'hA5}, rsp);
        prog_u.xfer({OPC_WR_EE_PAGE, 8'h01, 8'h20, 8'h00}, rsp);
        wait_ready();
        rq({OPC_RD_EE, 8'h01, 8'h21, 8'h00}, 8'hA5);
        rq({OPC_RD_EE, 8'h01, 8'h23, 8'h00}, 8'hC3);
        rq({OPC_RD_EE, 8'h01, 8'h20, 8'h00}, ERASED_BYTE);
        $display("test eeprom done");
    endtask
    task automatic t_config();
        logic [7:0] ws [4] = '{SUB_WR_FUSE_LO, SUB_WR_FUSE_HI, SUB_WR_FUSE_EXT, SUB_WR_LOCK};
        logic [15:0] rs [4] = '{16'h5000, 16'h5808, 16'h5008, 16'h5800};
        logic [7:0] sig [3] = '{8'h11, 8'h22, 8'h33};
        for (int k = 0; k < 4; k++) begin
            prog_u.xfer({OPC_AC_GROUP, ws[k], 8'h00, 8'hF0 + 8'(k)}, rsp);
            wait_ready();
            rq({rs[k], 16'h0000}, 8'hF0 + 8'(k));
        end
        apb(1'b0, ADDR_CFG, '0, 32'hF2F1F0F3, 1'b0);
        foreach (sig[k]) rq({OPC_RD_SIG, 8'h00, 8'(k), 8'h00}, sig[k]);
        rq({OPC_RD_CAL, 24'h000000}, 8'h5A);
        $display("test config done");
    endtask
    task automatic t_exit();
        prog_u.set_reset(1'b1);
        chk_byte({6'h00, miso_oe, cpu_run}, 8'h01);
        prog_u.set_reset(1'b0);
        rq({OPC_RD_SIG, 24'h000000}, 8'h00);
        apb(1'b1, ADDR_CTRL, 32'h00000000, '0, 1'b0);
        repeat (2) @(posedge pclk);
        chk_byte({7'h00, miso_oe}, 8'h00);
        $display("test exit done");
    endtask

    initial begin
        err_total = 0;
        tests_run = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        prog_u.power_wait();
        t_enable();
        t_erase();
        t_flash();
        t_eeprom();
        t_config();
        t_exit();
        give_verdict();
    end
endmodule

// >>> tb/ssp_programmer.sv
// Behavioural in-system programmer driving the serial pins
`timescale 1ns/10ps
module ssp_programmer #(
    parameter int POWERUP_NS = 20000000
) (
    output ssp_pkg::ssp_pins_type pins,
    input wire logic miso
);
    import ssp_pkg::*;
    initial begin
        pins = '{rst_n: 1'b0, sck: 1'b0, mosi: 1'b0};
    end
    task automatic power_wait();
        #(POWERUP_NS);
    endtask
    task automatic xfer(input logic [31:0] cmd, output logic [31:0] rsp);
        rsp = '0;
        #3.7;
        for (int i = 31; i >= 0; i--) begin
            pins.mosi = cmd[i];
            #40;
            pins.sck = 1'b1;
            #38;
            rsp = {rsp[30:0], miso};
            #2;
            pins.sck = 1'b0;
        end
        #40;
        pins.mosi = ~pins.mosi;
        #60;
    endtask
    task automatic set_reset(input logic level);
        pins.rst_n = level;
        #100;
    endtask
    task automatic enable(output logic [7:0] echo);
        logic [31:0] r;
        for (int k = 0; k < 3; k++) begin
            xfer({OPC_AC_GROUP, SUB_PROG_EN, 16'h0000}, r);
            echo = r[15:8];
            if (echo === SUB_PROG_EN) break;
            set_reset(1'b1);
            set_reset(1'b0);
        end
    endtask
endmodule
